// ---- hdl/cogsd_top.sv ----
// Purpose: Auto-shutdown, dead-band, blanking and phase timing of a
//          complementary output generator, APB register slave
// Assumes: Event, comparator, fault and oscillator inputs synchronous
// Notes:   Output polarity, enables and event selection left outside
// Function
// [R1] Bit 7 reads shutdown state
// [R2] Bit 6 enables auto-restart
// [R3] Shutdown drives second output to bit 5
// [R4] Shutdown drives first output to bit 4
// [R5] Bit 3: limit timer match shuts down
// [R6] Bit 2: comparator two low shuts down
// [R7] Bit 1: comparator one low shuts down
// [R8] Bit 0: fault pin low shuts down
// [R9] Rising dead-band delays primary output
// [R10] Falling dead-band delays complementary output
// [R11] Rising blanking ignores falling events
// [R12] Falling blanking ignores rising events
// [R13] Phase count delays rising events
// [R14] Phase upper nibble reads zero
// [R15] Load bit copies buffers, self-clears
// [R16] Setting auto-restart clears shutdown flag
// [R17] Two-bit field selects generator clock
// [R18] Restart: software clear or sources idle
`timescale 1ns/1ps
module cogsd_top
   import cogsd_pkg::*;
#(
   parameter int CW = 4
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rising_event,
   input  wire logic        falling_event,
   input  wire logic        fault_input_pin_n,
   input  wire logic        comparator_one_output,
   input  wire logic        comparator_two_output,
   input  wire logic        internal_fast_oscillator,
   output logic             primary_output,
   output logic             complementary_output,
   output logic             irq
);
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0]  ctrl0_r, ctrl1_r, asd_r, db_r, blk_r;
   logic [3:0]  ph_r;
   logic [7:0]  db_buf_r, blk_buf_r;
   logic [3:0]  ph_buf_r;
   logic [7:0]  limit_timer_count, limit_timer_period;
   logic [IRQ_W-1:0] int_st_r, int_en_r;
   logic        wr_en, rd_en;
   logic        shutdown_input;
   logic        load_done;
   logic        shdn_set;
   logic        tick;
   logic [31:0] rdata_nxt;
   logic        addr_ok;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   // [R5] limit timer match
   // [R6] comparator two low
   // [R7] comparator one low
   // [R8] fault pin low
   assign shutdown_input =
      (asd_r[ASD_LIM_BIT]  &&
       (limit_timer_count == limit_timer_period)) ||
      (asd_r[ASD_CMP2_BIT] && !comparator_two_output) ||
      (asd_r[ASD_CMP1_BIT] && !comparator_one_output) ||
      (asd_r[ASD_FLT_BIT]  && !fault_input_pin_n);

   // -----------------------------------------------------------------
   // Generator clock select
   // -----------------------------------------------------------------
   logic [1:0] inst_div_r;
   logic       osc_d_r;
   cogsd_cs_type cs;
   assign cs = cogsd_cs_type'(ctrl0_r[CTL_CS_LSB +: 2]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inst_div_r <= 2'h0;
         osc_d_r    <= 1'b0;
      end else begin
         inst_div_r <= inst_div_r + 2'h1;
         osc_d_r    <= internal_fast_oscillator;
      end
   end

   // [R17] tick source chosen by select field; reserved stops counts
   always_comb begin
      case (cs)
         COGSD_CS_SYS:  tick = 1'b1;
         COGSD_CS_INST: tick = (inst_div_r == INST_DIV);
         COGSD_CS_OSC:  tick = internal_fast_oscillator && !osc_d_r;
         default:       tick = 1'b0;
      endcase
   end

   // -----------------------------------------------------------------
   // Register writes
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl0_r <= CTL_RESET;
         ctrl1_r <= CTL_RESET;
         db_r    <= CNT_RESET;
         blk_r   <= CNT_RESET;
         ph_r    <= CNT_RESET[3:0];
         limit_timer_count  <= 8'h00;
         limit_timer_period <= 8'hff;
      end else begin
         if (wr_en && paddr == CTRL0_OFS)
            ctrl0_r <= pwdata[7:0];
         // [R15] hardware clears load bit after transfer
         else if (load_done)
            ctrl0_r[CTL_LD_BIT] <= 1'b0;
         if (wr_en && paddr == CTRL1_OFS)   ctrl1_r <= pwdata[7:0];
         if (wr_en && paddr == DB_OFS)      db_r    <= pwdata[7:0];
         if (wr_en && paddr == BLK_OFS)     blk_r   <= pwdata[7:0];
         if (wr_en && paddr == PH_OFS)      ph_r    <= pwdata[3:0];
         if (wr_en && paddr == LIM_CNT_OFS)
            limit_timer_count <= pwdata[7:0];
         if (wr_en && paddr == LIM_PER_OFS)
            limit_timer_period <= pwdata[7:0];
      end
   end

   // Auto-shutdown register with hardware-owned flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         asd_r <= ASD_RESET;
      end else begin
         if (wr_en && paddr == ASD_OFS)
            asd_r[6:0] <= pwdata[6:0];
         // [R1] flag set wins over any clear
         if (shutdown_input)
            asd_r[ASD_FLAG_BIT] <= 1'b1;
         // [R16] enabling auto-restart clears flag
         else if (wr_en && paddr == ASD_OFS && pwdata[ASD_ARS_BIT] &&
                  !asd_r[ASD_ARS_BIT])
            asd_r[ASD_FLAG_BIT] <= 1'b0;
         // [R18] manual clear or auto leave when sources idle
         else if (wr_en && paddr == ASD_OFS)
            asd_r[ASD_FLAG_BIT] <= pwdata[ASD_FLAG_BIT];
         // [R2] auto-restart when enabled
         else if (asd_r[ASD_ARS_BIT])
            asd_r[ASD_FLAG_BIT] <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Buffer transfer
   // -----------------------------------------------------------------
   logic enabled;
   assign enabled = ctrl0_r[CTL_EN_BIT];
   // [R15] transfer all three together on next event
   assign load_done = enabled && ctrl0_r[CTL_LD_BIT] &&
                      (rising_event || falling_event);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         db_buf_r  <= CNT_RESET;
         blk_buf_r <= CNT_RESET;
         ph_buf_r  <= CNT_RESET[3:0];
      end else if (!enabled || load_done) begin
         db_buf_r  <= db_r;
         blk_buf_r <= blk_r;
         ph_buf_r  <= ph_r;
      end
   end

   // -----------------------------------------------------------------
   // Event timing
   // -----------------------------------------------------------------
   logic rise_ok, fall_ok;
   logic ph_busy, ph_done, dbr_busy, dbr_done, dbf_busy, dbf_done;
   logic bkr_busy, bkf_busy;
   logic rise_go;

   // [R12] rising ignored during falling blanking
   assign rise_ok = enabled && rising_event && !bkf_busy;
   // [R11] falling ignored during rising blanking
   assign fall_ok = enabled && falling_event && !bkr_busy;

   // [R13] phase delay on rising event
   cogsd_delay #(.W(CW)) u_phase (
      .pclk(pclk), .presetn(presetn), .start(rise_ok), .tick(tick),
      .count(ph_buf_r), .busy(ph_busy), .done(ph_done));
   assign rise_go = ph_done;

   cogsd_delay #(.W(CW)) u_blk_r (
      .pclk(pclk), .presetn(presetn), .start(rise_go), .tick(tick),
      .count(blk_buf_r[HI_LSB +: 4]), .busy(bkr_busy), .done());
   cogsd_delay #(.W(CW)) u_blk_f (
      .pclk(pclk), .presetn(presetn), .start(fall_ok), .tick(tick),
      .count(blk_buf_r[LO_LSB +: 4]), .busy(bkf_busy), .done());
   // [R9] rising dead-band
   cogsd_delay #(.W(CW)) u_db_r (
      .pclk(pclk), .presetn(presetn), .start(rise_go), .tick(tick),
      .count(db_buf_r[HI_LSB +: 4]), .busy(dbr_busy), .done(dbr_done));
   // [R10] falling dead-band
   cogsd_delay #(.W(CW)) u_db_f (
      .pclk(pclk), .presetn(presetn), .start(fall_ok), .tick(tick),
      .count(db_buf_r[LO_LSB +: 4]), .busy(dbf_busy), .done(dbf_done));

   // Raw phase: high after rising, low after falling
   logic phase_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         phase_r <= 1'b0;
      else if (!enabled)
         phase_r <= 1'b0;
      else if (rise_go)
         phase_r <= 1'b1;
      else if (fall_ok)
         phase_r <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   logic pri_nxt, cmp_nxt;
   always_comb begin
      pri_nxt = primary_output;
      cmp_nxt = complementary_output;
      if (asd_r[ASD_FLAG_BIT] || shutdown_input || !enabled) begin
         // [R4] override level of first output
         pri_nxt = asd_r[ASD_LVL0_BIT];
         // [R3] override level of second output
         cmp_nxt = asd_r[ASD_LVL1_BIT];
      end else begin
         if (!phase_r)
            pri_nxt = 1'b0;
         else if (dbr_done)
            pri_nxt = 1'b1;
         if (phase_r || rise_go)
            cmp_nxt = 1'b0;
         else if (dbf_done)
            cmp_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_output       <= 1'b0;
         complementary_output <= 1'b0;
      end else begin
         primary_output       <= pri_nxt;
         complementary_output <= cmp_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Interrupts
   // -----------------------------------------------------------------
   assign shdn_set = shutdown_input && !asd_r[ASD_FLAG_BIT];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_st_r <= '0;
         int_en_r <= '0;
         irq      <= 1'b0;
      end else begin
         if (wr_en && paddr == INT_EN_OFS)
            int_en_r <= pwdata[IRQ_W-1:0];
         for (int i = 0; i < IRQ_W; i++) begin
            if ((i == IRQ_SHDN_BIT && shdn_set) ||
                (i == IRQ_LOAD_BIT && load_done))
               int_st_r[i] <= 1'b1;
            else if (wr_en && paddr == INT_CLR_OFS && pwdata[i])
               int_st_r[i] <= 1'b0;
         end
         irq <= |(int_st_r & int_en_r);
      end
   end

   // -----------------------------------------------------------------
   // APB read path
   // -----------------------------------------------------------------
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      addr_ok   = 1'b1;
      case (paddr)
         CTRL0_OFS:   rdata_nxt[7:0] = ctrl0_r;
         CTRL1_OFS:   rdata_nxt[7:0] = ctrl1_r;
         ASD_OFS:     rdata_nxt[7:0] = asd_r;
         DB_OFS:      rdata_nxt[7:0] = db_r;
         BLK_OFS:     rdata_nxt[7:0] = blk_r;
         // [R14] upper nibble reads zero
         PH_OFS:      rdata_nxt[7:0] = {4'h0, ph_r};
         INT_ST_OFS:  rdata_nxt[IRQ_W-1:0] = int_st_r;
         INT_EN_OFS:  rdata_nxt[IRQ_W-1:0] = int_en_r;
         INT_CLR_OFS: rdata_nxt = 32'h0000_0000;
         LIM_CNT_OFS: rdata_nxt[7:0] = limit_timer_count;
         LIM_PER_OFS: rdata_nxt[7:0] = limit_timer_period;
         default:     addr_ok = 1'b0;
      endcase
   end

   // Zero-wait slave; prdata registered during setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b1;
         pslverr <= 1'b0;
      end else begin
         pready  <= 1'b1;
         if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
            pslverr <= !addr_ok;
         end
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   property p_flag_on_fault;
      @(posedge pclk) disable iff (!presetn)
      (asd_r[ASD_FLT_BIT] && !fault_input_pin_n) |=> asd_r[ASD_FLAG_BIT];
   endproperty
   a_flag_on_fault: assert property (p_flag_on_fault) // [R8]
      else $error("fault pin did not set shutdown flag");

   property p_cmp1;
      @(posedge pclk) disable iff (!presetn)
      (asd_r[ASD_CMP1_BIT] && !comparator_one_output) |=>
         asd_r[ASD_FLAG_BIT];
   endproperty
   a_cmp1: assert property (p_cmp1) // [R7]
      else $error("comparator one did not shut down");

   property p_cmp2;
      @(posedge pclk) disable iff (!presetn)
      (asd_r[ASD_CMP2_BIT] && !comparator_two_output) |=>
         asd_r[ASD_FLAG_BIT];
   endproperty
   a_cmp2: assert property (p_cmp2) // [R6]
      else $error("comparator two did not shut down");

   property p_lvl0;
      @(posedge pclk) disable iff (!presetn)
      asd_r[ASD_FLAG_BIT] |=> primary_output == $past(asd_r[ASD_LVL0_BIT]);
   endproperty
   a_lvl0: assert property (p_lvl0) // [R4]
      else $error("first output not at override level");

   property p_lvl1;
      @(posedge pclk) disable iff (!presetn)
      asd_r[ASD_FLAG_BIT] |=>
         complementary_output == $past(asd_r[ASD_LVL1_BIT]);
   endproperty
   a_lvl1: assert property (p_lvl1) // [R3]
      else $error("second output not at override level");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (asd_r[ASD_FLAG_BIT] && !asd_r[ASD_ARS_BIT] &&
       !(wr_en && paddr == ASD_OFS)) |=> asd_r[ASD_FLAG_BIT];
   endproperty
   a_hold: assert property (p_hold) // [R18]
      else $error("shutdown left without software clear");

   property p_ph_zero;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == PH_OFS) |=>
         prdata[7:4] == 4'h0;
   endproperty
   a_ph_zero: assert property (p_ph_zero) // [R14]
      else $error("phase upper nibble not zero");

   property p_ld_clear;
      @(posedge pclk) disable iff (!presetn)
      (load_done && !(wr_en && paddr == CTRL0_OFS)) |=>
         !ctrl0_r[CTL_LD_BIT] && db_buf_r == $past(db_r);
   endproperty
   a_ld_clear: assert property (p_ld_clear) // [R15]
      else $error("load bit not cleared after transfer");

   property p_blank;
      @(posedge pclk) disable iff (!presetn)
      bkr_busy |-> !fall_ok;
   endproperty
   a_blank: assert property (p_blank) // [R11]
      else $error("falling event accepted during blanking");

   c_shutdown: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(asd_r[ASD_FLAG_BIT]));
   c_restart: cover property (@(posedge pclk) disable iff (!presetn)
      $fell(asd_r[ASD_FLAG_BIT]) && asd_r[ASD_ARS_BIT]);
   c_load: cover property (@(posedge pclk) disable iff (!presetn)
      load_done);
   c_pri: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(primary_output) && !asd_r[ASD_FLAG_BIT]);
endmodule

// ---- hdl/cogsd_pkg.sv ----
// Purpose: Constants for the complementary output shutdown/timing block
// Assumes: APB register map, one aligned 32-bit word per register
// Notes:   Offsets are local choices, one aligned word apart
package cogsd_pkg;
   localparam logic [7:0] CTRL0_OFS   = 8'h00;
   localparam logic [7:0] CTRL1_OFS   = 8'h04;
   localparam logic [7:0] ASD_OFS     = 8'h08;
   localparam logic [7:0] DB_OFS      = 8'h0c;
   localparam logic [7:0] BLK_OFS     = 8'h10;
   localparam logic [7:0] PH_OFS      = 8'h14;
   localparam logic [7:0] INT_ST_OFS  = 8'h18;
   localparam logic [7:0] INT_EN_OFS  = 8'h1c;
   localparam logic [7:0] INT_CLR_OFS = 8'h20;
   localparam logic [7:0] LIM_CNT_OFS = 8'h24;
   localparam logic [7:0] LIM_PER_OFS = 8'h28;
   // Auto-shutdown fields
   localparam int ASD_FLAG_BIT  = 7;
   localparam int ASD_ARS_BIT   = 6;
   localparam int ASD_LVL1_BIT  = 5;
   localparam int ASD_LVL0_BIT  = 4;
   localparam int ASD_LIM_BIT   = 3;
   localparam int ASD_CMP2_BIT  = 2;
   localparam int ASD_CMP1_BIT  = 1;
   localparam int ASD_FLT_BIT   = 0;
   // Control zero fields
   localparam int CTL_EN_BIT    = 7;
   localparam int CTL_LD_BIT    = 2;
   localparam int CTL_CS_LSB    = 0;
   // Nibble fields of count registers
   localparam int HI_LSB        = 4;
   localparam int LO_LSB        = 0;
   localparam logic [7:0] ASD_RESET  = 8'h00;
   localparam logic [7:0] CTL_RESET  = 8'h00;
   localparam logic [7:0] CNT_RESET  = 8'h00;
   // Interrupt status bits
   localparam int IRQ_SHDN_BIT  = 0;
   localparam int IRQ_LOAD_BIT  = 1;
   localparam int IRQ_W         = 2;
   typedef enum logic [1:0] {
      COGSD_CS_SYS  = 2'b00,
      COGSD_CS_INST = 2'b01,
      COGSD_CS_OSC  = 2'b10,
      COGSD_CS_RSV  = 2'b11
   } cogsd_cs_type;
   typedef enum logic [1:0] {
      COGSD_IDLE  = 2'b00,
      COGSD_DELAY = 2'b01,
      COGSD_RUN   = 2'b11
   } cogsd_state_type;
   // Instruction clock is one quarter of system clock
   localparam logic [1:0] INST_DIV = 2'h3;
endpackage

// ---- hdl/cogsd_delay.sv ----
// Purpose: Counts a programmed number of generator ticks then pulses
// Assumes: tick is a one-cycle enable from the clock selector
// Notes:   A new start restarts the count
`timescale 1ns/1ps
module cogsd_delay
   import cogsd_pkg::*;
#(
   parameter int W = 4
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         start,
   input  wire logic         tick,
   input  wire logic [W-1:0] count,
   output logic              busy,
   output logic              done
);
   logic [W-1:0] cnt_r;
   logic         busy_r;
   logic         done_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            if (count == '0) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               cnt_r  <= count;
               busy_r <= 1'b1;
            end
         end else if (busy_r && tick) begin
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end
   assign busy = busy_r;
   assign done = done_r;
endmodule

// ---- tb/cogsd_partner.sv ----
// Purpose: Far-side model: fault pin, comparators, fast oscillator
// Assumes: Bench requests are active-high shutdown demands
// Notes:   Fault pin idles high through its pull-up
`timescale 1ns/1ps
module cogsd_partner
   import cogsd_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic req_fault,
   input  wire logic req_cmp1,
   input  wire logic req_cmp2,
   input  wire logic osc_run,
   output logic      fault_input_pin_n,
   output logic      comparator_one_output,
   output logic      comparator_two_output,
   output logic      internal_fast_oscillator
);
   // Sources settle one cycle late, as a real comparator would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_input_pin_n     <= 1'b1;
         comparator_one_output <= 1'b1;
         comparator_two_output <= 1'b1;
      end else begin
         fault_input_pin_n     <= !req_fault;
         comparator_one_output <= !req_cmp1;
         comparator_two_output <= !req_cmp2;
      end
   end
   // Oscillator stands still unless asked to run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         internal_fast_oscillator <= 1'b0;
      end else if (osc_run) begin
         internal_fast_oscillator <= !internal_fast_oscillator;
      end
   end
endmodule

// ---- tb/cogsd_top_test.sv ----
// Purpose: Self-checking bench for the shutdown and timing block
// Assumes: Zero-wait APB slave, partner model on the source pins
// Notes:   Delays compared as differences from a zero-count baseline
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module cogsd_top_test
   import cogsd_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, sl;
   logic [7:0]  paddr, r;
   logic [31:0] pwdata, prdata, q, a0, b;
   logic        pready, pslverr, rise_ev, fall_ev, irq;
   logic        flt_n, c1, c2, osc, p_out, c_out;
   logic        rq_f, rq_c1, rq_c2, osc_run;
   logic [1:0]  lv;
   logic [7:0]  m [int];
   logic [7:0]  cofs [5] = '{CTRL1_OFS, DB_OFS, BLK_OFS, PH_OFS, LIM_PER_OFS};
   int          err_total, compares, seed, br, bf, d, k1, k2, k3;

   cogsd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rising_event(rise_ev), .falling_event(fall_ev),
      .fault_input_pin_n(flt_n), .comparator_one_output(c1),
      .comparator_two_output(c2), .internal_fast_oscillator(osc),
      .primary_output(p_out), .complementary_output(c_out), .irq(irq));
   cogsd_partner u_far (.pclk(pclk), .presetn(presetn), .req_fault(rq_f),
      .req_cmp1(rq_c1), .req_cmp2(rq_c2), .osc_run(osc_run),
      .fault_input_pin_n(flt_n), .comparator_one_output(c1),
      .comparator_two_output(c2), .internal_fast_oscillator(osc));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic end_of_test;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] dw);
      int k;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= dw;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q  = prdata;
      sl = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (k >= 20) begin
         err_total++;
         end_of_test;
      end
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, q)
   endtask
   task automatic ev(input logic f);
      rise_ev <= !f;
      fall_ev <= f;
      @(posedge pclk);
      rise_ev <= 1'b0;
      fall_ev <= 1'b0;
      @(posedge pclk);
   endtask
   // Cycles from event to output rise, -1 when it never comes
   task automatic meas(input logic f, output int c);
      ev(!f);
      wt(40);
      ev(f);
      c = 0;
      while ((f ? c_out : p_out) !== 1'b1 && c < 200) begin
         @(posedge pclk);
         c++;
      end
      if (c >= 200) c = -1;
   endtask
   // Counts load straight into buffers while disabled
   task automatic cfg(input logic [7:0] db, bk, ph, ctl);
      apb(1'b1, CTRL0_OFS, 32'h0);
      apb(1'b1, DB_OFS, {24'h0, db});
      apb(1'b1, BLK_OFS, {24'h0, bk});
      apb(1'b1, PH_OFS, {24'h0, ph});
      apb(1'b1, CTRL0_OFS, {24'h0, ctl});
   endtask
   task automatic src(input int i, input logic on);
      case (i)
         0: rq_f <= on;
         1: rq_c1 <= on;
         2: rq_c2 <= on;
         default: apb(1'b1, LIM_CNT_OFS,
                      {24'h0, on ? m[LIM_PER_OFS] : ~m[LIM_PER_OFS]});
      endcase
      wt(4);
   endtask
   task automatic blank(input logic f, input logic e);
      ev(!f);
      wt(40);
      ev(f);
      wt(3);
      ev(!f);
      wt(8);
      `CHK("blank", e, p_out)
   endtask

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      repeat (100000) @(posedge pclk);
      err_total++;
      end_of_test;
   end

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, rise_ev, fall_ev} = '0;
      {rq_f, rq_c1, rq_c2, osc_run} = '0;
      paddr = '0;
      pwdata = '0;
      presetn = 1'b0;
      err_total = 0;
      compares = 0;
      seed = 32'hd3eb;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd("asd", ASD_OFS, {24'h0, ASD_RESET});
      rd("ctl0", CTRL0_OFS, {24'h0, CTL_RESET});
      rd("ist", INT_ST_OFS, 32'h0);
      apb(1'b0, 8'h3c, 32'h5a);
      `CHK("slverr", 1'b1, sl)
      `CHK("unmapped", 32'h0, q)
      for (int i = 0; i < 5; i++) begin
         r = $random(seed);
         apb(1'b1, cofs[i], {24'h0, r});
         m[cofs[i]] = (cofs[i] == PH_OFS) ? (r & 8'h0f) : r;
         rd("cnt", cofs[i], {24'h0, m[cofs[i]]});
      end
      // Each shutdown source, off then on, with interrupt
      apb(1'b1, CTRL0_OFS, 32'h80);
      for (int i = 0; i < 4; i++) begin
         lv = 2'(3 - i);
         a0 = {26'h0, lv, 4'h0};
         b = 32'h1 << i;
         apb(1'b1, INT_CLR_OFS, 32'h3);
         apb(1'b1, INT_EN_OFS, 32'h1);
         apb(1'b1, ASD_OFS, a0);
         src(i, 1'b1);
         rd("off", ASD_OFS, a0);
         apb(1'b1, ASD_OFS, a0 | b);
         wt(2);
         rd("shdn", ASD_OFS, 32'h80 | a0 | b);
         `CHK("out0", lv[0], p_out)
         `CHK("out1", lv[1], c_out)
         `CHK("irq", 1'b1, irq)
         src(i, 1'b0);
         rd("held", ASD_OFS, 32'h80 | a0 | b);
         apb(1'b1, INT_EN_OFS, 32'h0);
         wt(2);
         `CHK("mask", 1'b0, irq)
         rd("ist", INT_ST_OFS, 32'h1);
         apb(1'b1, INT_CLR_OFS, 32'h1);
         rd("iclr", INT_ST_OFS, 32'h0);
         apb(1'b1, ASD_OFS, a0);
         rd("clr", ASD_OFS, a0);
      end
      // Auto-restart
      apb(1'b1, ASD_OFS, 32'h01);
      src(0, 1'b1);
      src(0, 1'b0);
      rd("sticky", ASD_OFS, 32'h81);
      apb(1'b1, ASD_OFS, 32'hc1);
      wt(2);
      rd("arst", ASD_OFS, 32'h41);
      src(0, 1'b1);
      rd("again", ASD_OFS, 32'hc1);
      src(0, 1'b0);
      rd("resume", ASD_OFS, 32'h41);
      apb(1'b1, ASD_OFS, 32'h0);
      // Dead band, phase and buffered load
      cfg(8'h00, 8'h00, 8'h00, 8'h80);
      meas(1'b0, br);
      meas(1'b1, bf);
      `CHK("base", 1'b1, br > 0 && bf > 0 && br < 8 && bf < 8)
      k1 = $random(seed) & 15;
      k2 = $random(seed) & 15;
      k3 = $random(seed) & 15;
      cfg(8'(k1 * 16 + k2), 8'h00, 8'(k3), 8'h80);
      meas(1'b0, d);
      `CHK("rise", br + k1 + k3, d)
      meas(1'b1, d);
      `CHK("fall", bf + k2, d)
      apb(1'b1, DB_OFS, 32'h0);
      apb(1'b1, PH_OFS, 32'h0);
      meas(1'b0, d);
      `CHK("hold", br + k1 + k3, d)
      apb(1'b1, CTRL0_OFS, 32'h84);
      meas(1'b0, d);
      `CHK("load", br, d)
      rd("ldclr", CTRL0_OFS, 32'h80);
      rd("ild", INT_ST_OFS, 32'h3);
      for (int j = 0; j < 2; j++) begin
         cfg(8'h00, j ? 8'hff : 8'h00, 8'h00, 8'h80);
         blank(1'b0, j[0]);
         blank(1'b1, !j[0]);
      end
      // Generator clock sources
      cfg(8'h30, 8'h00, 8'h00, 8'h83);
      meas(1'b0, d);
      `CHK("cs3", -1, d)
      apb(1'b1, CTRL0_OFS, 32'h82);
      meas(1'b0, d);
      `CHK("osc_off", -1, d)
      osc_run <= 1'b1;
      meas(1'b0, d);
      `CHK("osc_on", 1'b1, d > 0)
      apb(1'b1, CTRL0_OFS, 32'h81);
      meas(1'b0, d);
      `CHK("inst", 1'b1, d > br + 6 && d < br + 24)
      end_of_test;
   end
endmodule
